// ### rtl/rx_symbol_sync.sv
/*
 * Receive symbol alignment and synchronisation state machine.
 * Assumes the deserialiser word and decoder results are synchronous to
 * clk_sys_i; the decoder sits outside and returns one result per word.
 */
`timescale 1ns/10ps
module rx_symbol_sync
    import rx_symbol_sync_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              reset_i,
    // Deserialiser word
    input  wire logic [IN_W-1:0]   serdes_data_i,
    input  wire logic              serdes_valid_i,
    // Lane control
    input  wire comma_mode_t       comma_mode_i,
    input  wire logic              full_reinit_command_i,
    input  wire logic              soft_reinit_command_i,
    // Aligned symbols to the decoder
    output logic [IN_W-1:0]        sym_word_o,
    output logic                   sym_valid_o,
    output logic                   sym_comma_o,
    output logic                   realign_o,
    // Decoder results
    input  wire logic              dec_valid_i,
    output logic                   dec_ready_o,
    input  wire dec_word_t         dec_word_i,
    // Words downstream
    output logic                   out_valid_o,
    input  wire logic              out_ready_i,
    output rx_word_t               out_word_o,
    // Status
    output sync_state_t            sync_state_o,
    output logic [ERR_CNT_W-1:0]   err_count_o,
    output logic [OFF_W-1:0]       bit_offset_o
);

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    // ----------------------------------------------------------------
    // Comma search
    // ----------------------------------------------------------------
    logic [IN_W-1:0]  prev_q;
    logic [OFF_W-1:0] off_q;
    logic             locked_q;
    logic [IN_W-1:0]  sym_word_q;
    logic             sym_valid_q;
    logic             comma_q;
    logic             realign_q;
    logic [IN_W-1:0]  hit;
    logic [OFF_W-1:0] first_off;

    // Older word low: a comma straddling two words is seen exactly once
    wire [WIN_W-1:0] window     = {serdes_data_i, prev_q};
    wire             accept_pos = (comma_mode_i != comma_neg_only);
    wire             accept_neg = (comma_mode_i != comma_pos_only);

    for (genvar g = 0; g < IN_W; g++) begin : g_match
        // Full eight-bit compare, never the seven-bit core alone
        assign hit[g] = (accept_pos && window[g +: COMMA_W] == COMMA_POS)
                      | (accept_neg && window[g +: COMMA_W] == COMMA_NEG);
    end

    always_comb begin
        first_off = OFF_RESET;
        for (int i = IN_W - 1; i >= 0; i--) begin
            if (hit[i]) begin
                first_off = OFF_W'(i);
            end
        end
    end

    wire             found     = |hit;
    wire [OFF_W-1:0] new_off   = found ? first_off : off_q;
    // Any offset change moves the comma out of symbol 0 of the word
    wire             realign_d = serdes_valid_i & found & locked_q
                               & (first_off != off_q);

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            prev_q      <= '0;
            off_q       <= OFF_RESET;
            locked_q    <= 1'b0;
            sym_word_q  <= '0;
            sym_valid_q <= 1'b0;
            comma_q     <= 1'b0;
            realign_q   <= 1'b0;
        end else if (serdes_valid_i) begin
            prev_q      <= serdes_data_i;
            off_q       <= new_off;
            locked_q    <= locked_q | found;
            // Comma lands in symbol 0, so words are aligned too
            sym_word_q  <= window[new_off +: IN_W];
            sym_valid_q <= 1'b1;
            comma_q     <= found;
            realign_q   <= realign_d;
        end else begin
            sym_valid_q <= 1'b0;
            comma_q     <= 1'b0;
            realign_q   <= 1'b0;
        end
    end

    lowest_comma_a: assert property (
        serdes_valid_i && window[COMMA_W-1:0] == COMMA_POS
            && comma_mode_i != comma_neg_only
        |=> comma_q && off_q == OFF_RESET)
        else $error("lowest comma not adopted");

    offset_move_a: assert property (
        realign_d |=> realign_q && off_q == $past(first_off) && sym_valid_q)
        else $error("new comma offset not adopted");

    // ----------------------------------------------------------------
    // Decoder results
    // ----------------------------------------------------------------
    logic              buf_ready;
    logic [SYMS-1:0]   k00_sym;
    rx_word_t          sub_word;

    wire dec_take  = dec_valid_i & buf_ready;
    wire any_err   = |dec_word_i.sym_err;

    for (genvar s = 0; s < SYMS; s++) begin : g_sub
        wire [BYTE_W-1:0] in_byte = dec_word_i.word.data[s*BYTE_W +: BYTE_W];
        assign k00_sym[s] = dec_word_i.word.is_ctrl[s] && in_byte == K00_BYTE;
        // Bad symbol becomes K0.0
        assign sub_word.data[s*BYTE_W +: BYTE_W] =
            dec_word_i.sym_err[s] ? K00_BYTE : in_byte;
        assign sub_word.is_ctrl[s] =
            dec_word_i.sym_err[s] | dec_word_i.word.is_ctrl[s];
    end

    wire word_bad = any_err | (|k00_sym);

    // ----------------------------------------------------------------
    // Synchronisation state machine
    // ----------------------------------------------------------------
    sync_state_t          state_q;
    sync_state_t          state_d;
    logic                 enter_check;
    logic [ERR_CNT_W-1:0] err_cnt_q;
    logic [ERR_CNT_W-1:0] err_cnt_d;

    wire [ERR_CNT_W-1:0] err_n   = ERR_CNT_W'($countones(dec_word_i.sym_err));
    wire [ERR_CNT_W-1:0] err_sum = err_cnt_q + err_n;
    wire                 over    = dec_take && err_sum > ERR_LIMIT;
    wire                 all_ok  = dec_take && !any_err;

    always_comb begin
        state_d     = state_q;
        enter_check = 1'b0;
        unique case (state_q)
            sync_lost_state: begin
                if (full_reinit_command_i) begin
                    state_d = sync_lost_state;
                end else if (comma_q) begin
                    state_d     = sync_checking_state;
                    enter_check = 1'b1;
                end
            end
            sync_checking_state: begin
                if (full_reinit_command_i) begin
                    state_d = sync_lost_state;
                end else if (soft_reinit_command_i) begin
                    enter_check = 1'b1;
                end else if (realign_q) begin
                    state_d = sync_lost_state;
                end else if (over) begin
                    state_d = sync_lost_state;
                end else if (all_ok) begin
                    state_d = sync_ready_state;
                end
            end
            sync_ready_state: begin
                if (full_reinit_command_i) begin
                    state_d = sync_lost_state;
                end else if (soft_reinit_command_i) begin
                    state_d     = sync_checking_state;
                    enter_check = 1'b1;
                end else if (dec_take && any_err) begin
                    state_d     = sync_checking_state;
                    enter_check = 1'b1;
                end else if (realign_q) begin
                    state_d = sync_lost_state;
                end
            end
            default: begin
                state_d = sync_lost_state;
            end
        endcase
    end

    // Counter only lives inside a checking episode
    assign err_cnt_d = (state_d != sync_checking_state) ? ERR_CNT_ZERO
                     : enter_check ? ERR_CNT_ZERO
                     : dec_take ? err_sum
                     : err_cnt_q;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_q   <= sync_lost_state;
            err_cnt_q <= ERR_CNT_ZERO;
        end else begin
            state_q   <= state_d;
            err_cnt_q <= err_cnt_d;
        end
    end

    full_reinit_a: assert property (
        full_reinit_command_i |=> state_q == sync_lost_state)
        else $error("full reinit did not lose sync");

    comma_check_a: assert property (
        state_q == sync_lost_state && comma_q && !full_reinit_command_i
        |=> state_q == sync_checking_state && err_cnt_q == ERR_CNT_ZERO)
        else $error("comma did not start checking");

    check_realign_a: assert property (
        state_q == sync_checking_state && realign_q
            && !full_reinit_command_i && !soft_reinit_command_i
        |=> state_q == sync_lost_state)
        else $error("realign in checking kept sync");

    err_limit_a: assert property (
        state_q == sync_checking_state && over && !realign_q
            && !full_reinit_command_i && !soft_reinit_command_i
        |=> state_q == sync_lost_state)
        else $error("error limit did not lose sync");

    ready_entry_a: assert property (
        state_q == sync_ready_state && $past(state_q) == sync_checking_state
        |-> $past(dec_take) && $past(dec_word_i.sym_err) == '0)
        else $error("ready entered without valid word");

    ready_error_a: assert property (
        state_q == sync_ready_state && dec_take && any_err
            && !full_reinit_command_i && !soft_reinit_command_i
        |=> state_q == sync_checking_state && err_cnt_q == ERR_CNT_ZERO)
        else $error("error in ready not handled");

    count_zero_a: assert property (
        state_q != sync_checking_state |-> err_cnt_q == ERR_CNT_ZERO)
        else $error("error count outside checking");

    count_hold_a: assert property (
        state_q == sync_checking_state && state_d == sync_checking_state
            && !enter_check && dec_take
        |=> err_cnt_q == $past(err_sum))
        else $error("bad symbols not counted");

    // ----------------------------------------------------------------
    // Word replacement and buffering
    // ----------------------------------------------------------------
    rx_word_t held_q;
    logic     held_valid_q;
    logic     held_bad_q;
    logic     held_lost_q;

    wire      pass_ok  = (state_q == sync_ready_state);
    wire      emit_bad = held_bad_q | word_bad;
    rx_word_t err_word;
    rx_word_t emit_word;

    assign err_word.data    = RX_ERR_DATA;
    assign err_word.is_ctrl = RX_ERR_CTRL;
    assign emit_word        = emit_bad ? err_word : held_q;

    // One word is held back so a later error can still spoil it
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            held_q       <= '0;
            held_lost_q  <= 1'b0;
            held_valid_q <= 1'b0;
            held_bad_q   <= 1'b0;
        end else if (dec_take) begin
            held_q       <= sub_word;
            held_lost_q  <= (state_q != sync_ready_state);
            held_valid_q <= 1'b1;
            held_bad_q   <= word_bad | ~pass_ok;
        end
    end

    lost_replace_a: assert property (
        dec_take && held_valid_q && held_lost_q |-> emit_word == err_word)
        else $error("word passed while not in sync");

    prev_spoil_a: assert property (
        held_valid_q && dec_take && word_bad |-> emit_word == err_word)
        else $error("word before error passed");

    rx_word_buffer #(
        .WIDTH       ($bits(rx_word_t))
    ) u_buf (
        .clk_sys_i   (clk_sys_i),
        .reset_i     (reset_i),
        .in_valid_i  (dec_take & held_valid_q),
        .in_ready_o  (buf_ready),
        .in_data_i   (emit_word),
        .out_valid_o (out_valid_o),
        .out_ready_i (out_ready_i),
        .out_data_o  (out_word_o)
    );

    reach_ready_c: cover property (
        state_q == sync_checking_state ##1 state_q == sync_ready_state);
    limit_hit_c: cover property (
        state_q == sync_checking_state && over);
    ready_realign_c: cover property (
        state_q == sync_ready_state && realign_q);
    buffer_stall_c: cover property (
        dec_valid_i && !buf_ready);

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign sym_word_o   = sym_word_q;
    assign sym_valid_o  = sym_valid_q;
    assign sym_comma_o  = comma_q;
    assign realign_o    = realign_q;
    assign dec_ready_o  = buf_ready;
    assign sync_state_o = state_q;
    assign err_count_o  = err_cnt_q;
    assign bit_offset_o = off_q;

endmodule : rx_symbol_sync

// ### pkg/rx_symbol_sync_pkg.sv
/*
 * Constants, field layouts and types of the receive symbol alignment
 * and synchronisation block.
 * Assumes a 40-bit deserialiser word holding four 10-bit symbols,
 * least significant bit received first.
 */
package rx_symbol_sync_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int SYM_W     = 10;
    localparam int SYMS      = 4;
    localparam int IN_W      = SYM_W * SYMS;
    localparam int WIN_W     = 2 * IN_W;
    localparam int OFF_W     = 6;
    localparam int COMMA_W   = 8;
    localparam int BYTE_W    = 8;
    localparam int DATA_W    = BYTE_W * SYMS;
    localparam int ERR_CNT_W = 4;
    localparam int BUF_DEPTH = 2;

    // ----------------------------------------------------------------
    // Codes
    // ----------------------------------------------------------------
    // Comma bits as received, bit 0 first on the line
    localparam logic [COMMA_W-1:0]   COMMA_POS    = 8'h7c;
    localparam logic [COMMA_W-1:0]   COMMA_NEG    = 8'h83;
    localparam logic [ERR_CNT_W-1:0] ERR_LIMIT    = 4'h4;
    localparam logic [ERR_CNT_W-1:0] ERR_CNT_ZERO = 4'h0;
    localparam logic [OFF_W-1:0]     OFF_RESET    = 6'h00;
    // Error control symbol substituted for a bad symbol
    localparam logic [BYTE_W-1:0]    K00_BYTE     = 8'h00;
    // Receive error control word; the code is arbitrary
    localparam logic [DATA_W-1:0]    RX_ERR_DATA  = 32'h0000_00fe;
    localparam logic [SYMS-1:0]      RX_ERR_CTRL  = 4'h1;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        comma_both,
        comma_pos_only,
        comma_neg_only
    } comma_mode_t;

    typedef enum logic [1:0] {
        sync_lost_state,
        sync_checking_state,
        sync_ready_state
    } sync_state_t;

    typedef struct packed {
        logic [SYMS-1:0]   is_ctrl;
        logic [DATA_W-1:0] data;
    } rx_word_t;

    typedef struct packed {
        rx_word_t        word;
        logic [SYMS-1:0] sym_err;
    } dec_word_t;

endpackage : rx_symbol_sync_pkg

// ### rtl/rx_word_buffer.sv
/*
 * Two-entry word buffer with valid and ready on both sides.
 * Assumes one clock and a synchronous active-high reset; all outputs
 * come straight from flip-flops.
 */
`timescale 1ns/10ps
module rx_word_buffer
    import rx_symbol_sync_pkg::*;
#(
    parameter int WIDTH = $bits(rx_word_t)
) (
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             reset_i,
    // Filling side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Draining side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);

    // Entry 0 is the head, entry 1 the overflow slot
    logic [WIDTH-1:0]     ent_q [BUF_DEPTH];
    logic [BUF_DEPTH-1:0] full_q;
    logic [BUF_DEPTH-1:0] full_d;
    logic                 ready_q;

    wire push      = in_valid_i & ready_q;
    wire head_free = ~full_q[0] | out_ready_i;

    assign full_d[0] = head_free ? (full_q[1] | push) : 1'b1;
    assign full_d[1] = head_free ? 1'b0 : (full_q[1] | push);

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            full_q   <= '0;
            ready_q  <= 1'b1;
            ent_q[0] <= '0;
            ent_q[1] <= '0;
        end else begin
            full_q  <= full_d;
            // Ready is registered, so it drops while the slot is taken
            ready_q <= ~full_d[1];
            if (head_free && full_q[1]) begin
                ent_q[0] <= ent_q[1];
            end else if (head_free && push) begin
                ent_q[0] <= in_data_i;
            end else if (push) begin
                ent_q[1] <= in_data_i;
            end
        end
    end

    assign in_ready_o  = ready_q;
    assign out_valid_o = full_q[0];
    assign out_data_o  = ent_q[0];

endmodule : rx_word_buffer

// ### verification/rx_dec_model.sv
/* Behavioural decoder facing the symbol sync block.
   Assumes no new aligned word arrives while a result is still pending. */
`timescale 1ns/10ps
module rx_dec_model
    import rx_symbol_sync_pkg::*;
(
    // Clock and reset
    input  wire logic            clk_sys_i,
    input  wire logic            reset_i,
    // Aligned symbols and injected faults
    input  wire logic [IN_W-1:0] sym_word_i,
    input  wire logic            sym_valid_i,
    input  wire logic            sym_comma_i,
    input  wire logic [SYMS-1:0] err_mask_i,
    // Decoder result
    output logic                 dec_valid_o,
    input  wire logic            dec_ready_i,
    output dec_word_t            dec_word_o
);
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            dec_valid_o <= 1'b0;
            dec_word_o  <= '0;
        end else if (dec_valid_o && dec_ready_i) begin
            dec_valid_o <= 1'b0;
            // Released result shows the inverse, never a stale copy
            dec_word_o  <= dec_word_t'(~dec_word_o);
        end else if (sym_valid_i && !dec_valid_o) begin
            dec_valid_o        <= 1'b1;
            dec_word_o.sym_err <= err_mask_i;
            for (int i = 0; i < SYMS; i++) begin
                dec_word_o.word.data[i*BYTE_W+:BYTE_W] <=
                    err_mask_i[i] ? K00_BYTE : sym_word_i[i*SYM_W+:BYTE_W];
                dec_word_o.word.is_ctrl[i] <= err_mask_i[i] | (i == 0 && sym_comma_i);
            end
        end
    end
endmodule : rx_dec_model

// ### verification/rx_symbol_sync_test.sv
/* Self-checking bench of the symbol sync block with a behavioural decoder.
   Assumes one clock; words are sent one at a time, outputs may stall. */
`timescale 1ns/10ps
module rx_symbol_sync_test
    import rx_symbol_sync_pkg::*;
;
    logic                 clk_sys_i = 1'b0;
    logic                 reset_i = 1'b1;
    logic [IN_W-1:0]      serdes_data_i = '0;
    logic                 serdes_valid_i = 1'b0;
    comma_mode_t          comma_mode_i = comma_both;
    logic                 full_reinit_command_i = 1'b0;
    logic                 soft_reinit_command_i = 1'b0;
    logic                 out_ready_i = 1'b0;
    logic [SYMS-1:0]      err_mask = '0;
    logic [IN_W-1:0]      sym_word_o;
    logic                 sym_valid_o, sym_comma_o, realign_o;
    logic                 dec_valid_i, dec_ready_o, out_valid_o;
    dec_word_t            dec_word_i;
    rx_word_t             out_word_o, tw;
    rx_word_t             expq[$];
    sync_state_t          sync_state_o, m_st = sync_lost_state;
    logic [ERR_CNT_W-1:0] err_count_o;
    logic [OFF_W-1:0]     bit_offset_o, m_off = '0, ps = 6'h0d;
    logic [IN_W-1:0]      pa = {SYMS{10'h155}};
    logic [1:0]           pck = '0;
    logic [3:0]           pm = '0;
    logic [31:0]          rs = 32'h0000ec99;
    logic                 m_lock = 1'b0, tv = 1'b0, t_ok = 1'b0, saw_refuse = 1'b0;
    int                   m_cnt = 0, mismatches = 0, n_checks = 0, cyc = 0;
    // Op code, comma kind, stream shift, error mask
    localparam logic [15:0] OPS [36] = '{
        16'h00d0, 16'h00d0, 16'h1000, 16'h04d0, 16'h00d0, 16'h00d0, 16'h00d0, 16'h0cd0,
        16'h00d0, 16'h00d2, 16'h00d3, 16'h00d3, 16'h00d1, 16'h00d0, 16'h04d1, 16'h00d0,
        16'h1000, 16'h00d0, 16'h1000, 16'h00d0, 16'h2000, 16'h04d0, 16'h00df, 16'h05b0,
        16'h01b0, 16'h05b0, 16'h01b0, 16'h3001, 16'h09b0, 16'h05b0, 16'h01b0, 16'h3002,
        16'h05b0, 16'h09b0, 16'h01b0, 16'h3000};

    rx_symbol_sync u_dut (.clk_sys_i, .reset_i, .serdes_data_i, .serdes_valid_i,
        .comma_mode_i, .full_reinit_command_i, .soft_reinit_command_i, .sym_word_o,
        .sym_valid_o, .sym_comma_o, .realign_o, .dec_valid_i, .dec_ready_o, .dec_word_i,
        .out_valid_o, .out_ready_i, .out_word_o, .sync_state_o, .err_count_o, .bit_offset_o);
    rx_dec_model u_dec (.clk_sys_i, .reset_i, .sym_word_i(sym_word_o),
        .sym_valid_i(sym_valid_o), .sym_comma_i(sym_comma_o), .err_mask_i(err_mask),
        .dec_valid_o(dec_valid_i), .dec_ready_i(dec_ready_o), .dec_word_o(dec_word_i));

    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction : rnd

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    // ----------------------------------------------------------------
    // Stimulus and reference state machine
    // ----------------------------------------------------------------
    // The aligner sees each word one send late, so the model works on pa
    task automatic send(input logic [1:0] ck, input logic [OFF_W-1:0] s, input logic [3:0] m);
        logic [IN_W-1:0]   a;
        logic [2*IN_W-1:0] cat;
        logic [31:0]       r;
        logic              c, rl;
        sync_state_t       ts;
        int                k, n;
        r = rnd();
        for (k = 0; k < SYMS; k++) a[k*SYM_W+:SYM_W] = r[k] ? 10'h2aa : 10'h155;
        if (ck[0]) a[9:0] = 10'h27c;
        if (ck[1]) a[ck[0]*20+:10] = 10'h283;
        cat = {a, pa} >> (IN_W - s);
        c = (pck[0] && comma_mode_i != comma_neg_only)
            || (pck == 2'h2 && comma_mode_i != comma_pos_only);
        rl = c && m_lock && ps != m_off;
        if (c) m_off = ps;
        m_lock = m_lock | c;
        err_mask = pm;
        serdes_data_i = cat[IN_W-1:0];
        serdes_valid_i = 1'b1;
        @(negedge clk_sys_i);
        serdes_valid_i = 1'b0;
        serdes_data_i = ~serdes_data_i;
        check(sym_valid_o, 1'b1);
        check(sym_comma_o, c);
        check(realign_o, rl);
        check(bit_offset_o, m_off);
        if (m_off == ps && s == ps) check(sym_word_o, pa);
        if (rl && m_st != sync_lost_state) m_st = sync_lost_state;
        else if (c && m_st == sync_lost_state) m_st = sync_checking_state;
        ts = m_st;
        n = $countones(pm);
        if (m_st == sync_checking_state) begin
            if (m_cnt + n > int'(ERR_LIMIT)) m_st = sync_lost_state;
            else if (n == 0) m_st = sync_ready_state;
        end else if (m_st == sync_ready_state && n != 0) m_st = sync_checking_state;
        m_cnt = (ts == sync_checking_state && m_st == ts) ? m_cnt + n : 0;
        if (tv) expq.push_back(t_ok && n == 0 ? tw : rx_word_t'({RX_ERR_CTRL, RX_ERR_DATA}));
        tv = 1'b1;
        t_ok = ts == sync_ready_state && n == 0;
        for (k = 0; k < SYMS; k++) tw.data[k*BYTE_W+:BYTE_W] = pa[k*SYM_W+:BYTE_W];
        tw.is_ctrl = {3'b000, c};
        @(negedge clk_sys_i);
        k = 0;
        while (dec_valid_i !== 1'b0 && k < 300) begin
            @(negedge clk_sys_i);
            k++;
        end
        check(sync_state_o, m_st);
        check(err_count_o, m_cnt);
        pa = a;
        ps = s;
        pck = ck;
        pm = m;
    endtask : send

    task automatic reinit(input logic f, input logic s);
        full_reinit_command_i = f;
        soft_reinit_command_i = s;
        @(negedge clk_sys_i);
        full_reinit_command_i = 1'b0;
        soft_reinit_command_i = 1'b0;
        if (f) m_st = sync_lost_state;
        else if (m_st != sync_lost_state) m_st = sync_checking_state;
        m_cnt = 0;
        check(sync_state_o, m_st);
        check(err_count_o, m_cnt);
    endtask : reinit

    initial forever #5 clk_sys_i = ~clk_sys_i;

    // Long periodic stalls so the two-entry buffer fills and refuses
    always @(negedge clk_sys_i) begin
        cyc++;
        out_ready_i = cyc % 64 >= 40 && rnd() % 2 == 1;
    end

    // ----------------------------------------------------------------
    // Output watcher
    // ----------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        if (dec_ready_o === 1'b0) saw_refuse = 1'b1;
        if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
            if (expq.size() == 0) check(out_valid_o, 1'b0);
            else check(out_word_o, expq.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        mismatches++;
        give_verdict();
    end

    initial begin
        logic [31:0] r;
        int          k;
        repeat (16) @(negedge clk_sys_i);
        check(sync_state_o, sync_lost_state);
        check(err_count_o, ERR_CNT_ZERO);
        check(out_valid_o, 1'b0);
        reset_i = 1'b0;
        foreach (OPS[i]) begin
            case (OPS[i][15:12])
                4'h0: send(OPS[i][11:10], OPS[i][9:4], OPS[i][3:0]);
                4'h1: reinit(1'b0, 1'b1);
                4'h2: reinit(1'b1, 1'b0);
                default: comma_mode_i = comma_mode_t'(OPS[i][1:0]);
            endcase
        end
        repeat (24) begin
            r = rnd();
            send(r[13] ? 2'h0 : (r[12] ? 2'h2 : 2'h1), 6'h1b, r[3:0] & r[7:4] & r[11:8]);
        end
        // Comma at bit 0 of the window, then back to the main shift
        send(2'h1, 6'h00, 4'h0);
        send(2'h0, 6'h00, 4'h0);
        send(2'h0, 6'h1b, 4'h0);
        send(2'h0, 6'h1b, 4'h0);
        k = 0;
        while (expq.size() != 0 && k < 2000) begin
            @(negedge clk_sys_i);
            k++;
        end
        check(expq.size(), 0);
        check(saw_refuse, 1'b1);
        give_verdict();
    end
endmodule : rx_symbol_sync_test
